// [verification/packed_add_logic_execute_tb_top.sv]
// self-checking bench for the packed add and logic execute unit
`timescale 1ns/1ns
`default_nettype none
module packed_add_logic_execute_tb_top;
	logic                  clk_i, rst_n_i, valid_i, cond_true_i, use_cst_i;
	logic                  wr_even_o, wr_odd_o, illegal_o, uc_v, cd_v;
	packed_alu_pkg::op_t   op_i;
	packed_alu_pkg::unit_t unit_i;
	logic [6:0]            opfield_i, opf_v;
	logic [4:0]            cst_i, cs_v;
	logic [7:0]            src2_ext_i, ex_v;
	logic [31:0]           src1_i, src2_i, even_data_o, odd_data_o, even_q, odd_q, exp_even, exp_odd;
	int                    n_errors = 0;
	int                    check_count = 0;

	// unit under test and the register pair it writes
	packed_add_logic_execute dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .valid_i(valid_i), .cond_true_i(cond_true_i),
		.op_i(op_i), .unit_i(unit_i), .opfield_i(opfield_i), .use_cst_i(use_cst_i), .cst_i(cst_i), .src1_i(src1_i),
		.src2_i(src2_i), .src2_ext_i(src2_ext_i), .wr_even_o(wr_even_o), .wr_odd_o(wr_odd_o),
		.even_data_o(even_data_o), .odd_data_o(odd_data_o), .illegal_o(illegal_o));
	reg_pair_model regs (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_even_i(wr_even_o), .wr_odd_i(wr_odd_o),
		.even_data_i(even_data_o), .odd_data_i(odd_data_o), .even_q_o(even_q), .odd_q_o(odd_q));

	// 125 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic chk(input string what, input logic [31:0] exp, got);
	begin
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	end
	endtask

	task automatic wrap_up;
	begin
		if (n_errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask

	// present one instruction at a rising edge, modifiers from the _v variables
	task automatic drive(input packed_alu_pkg::op_t op, input packed_alu_pkg::unit_t un, input logic [31:0] s1, s2);
	begin
		valid_i <= 1'b1;
		op_i <= op;
		unit_i <= un;
		src1_i <= s1;
		src2_i <= s2;
		opfield_i <= opf_v;
		cst_i <= cs_v;
		use_cst_i <= uc_v;
		cond_true_i <= cd_v;
		src2_ext_i <= ex_v;
	end
	endtask

	// strobes {even, odd, illegal}; data held unless written
	task automatic judge(input logic [2:0] strb, input logic [31:0] ev, od);
	begin
		if (strb[2])
			exp_even = ev;
		if (strb[1])
			exp_odd = od;
		chk("strobes", {29'h0, strb}, {29'h0, wr_even_o, wr_odd_o, illegal_o});
		chk("even_data", exp_even, even_data_o);
		chk("odd_data", exp_odd, odd_data_o);
	end
	endtask

	// one instruction, answer judged just after the edge that takes it
	task automatic exec(input packed_alu_pkg::op_t op, input packed_alu_pkg::unit_t un, input logic [31:0] s1, s2,
		input logic [2:0] strb, input logic [31:0] ev, od);
	begin
		@(posedge clk_i);
		drive(op, un, s1, s2);
		@(posedge clk_i);
		valid_i <= 1'b0;
		#1 judge(strb, ev, od);
	end
	endtask

	task automatic t_paired;
		exec(packed_alu_pkg::OP_PAIRED_HALFWORD_ADD_SUB, packed_alu_pkg::UNIT_L, 32'h9000_8000, 32'h8000_9000,
			3'b110, 32'h1000_f000, 32'h1000_1000);
		exec(packed_alu_pkg::OP_PAIRED_HALFWORD_ADD_SUB, packed_alu_pkg::UNIT_L, 32'h7fff_8000, 32'hffff_ffff,
			3'b110, 32'h8000_8001, 32'h7ffe_7fff);
	endtask

	task automatic t_long;
		ex_v = 8'hff;
		opf_v = 7'h2b;
		exec(packed_alu_pkg::OP_UNSIGNED_LONG_ADD, packed_alu_pkg::UNIT_L, 32'h0000_325a, 32'hffff_ff12,
			3'b110, 32'h0000_316c, 32'h0000_0001);
		opf_v = 7'h29;
		exec(packed_alu_pkg::OP_UNSIGNED_LONG_ADD, packed_alu_pkg::UNIT_L, 32'h0000_325a, 32'hffff_ff12,
			3'b110, 32'h0000_316c, 32'h0000_0000);
		exec(packed_alu_pkg::OP_UNSIGNED_LONG_ADD, packed_alu_pkg::UNIT_L, 32'h0000_0001, 32'hffff_ffff,
			3'b110, 32'h0000_0000, 32'h0000_0000);
		ex_v = 8'h01;
		exec(packed_alu_pkg::OP_UNSIGNED_LONG_ADD, packed_alu_pkg::UNIT_L, 32'h0000_0003, 32'hffff_fffe,
			3'b110, 32'h0000_0001, 32'h0000_0002);
		ex_v = 8'h00;
	endtask

	// dual add on every legal unit, then the byte and logic ops
	task automatic t_lanes;
		for (int u = 0; u < 3; u++)
			exec(packed_alu_pkg::OP_DUAL_HALFWORD_ADD, packed_alu_pkg::unit_t'(u), 32'h0021_37e1, 32'h039a_e4b8,
				3'b100, 32'h03bb_1c99, 32'h0);
		exec(packed_alu_pkg::OP_DUAL_HALFWORD_ADD, packed_alu_pkg::UNIT_S, 32'h0001_ffff, 32'h0000_0001,
			3'b100, 32'h0001_0000, 32'h0);
		exec(packed_alu_pkg::OP_QUAD_BYTE_ADD, packed_alu_pkg::UNIT_L, 32'hff68_4e3d, 32'h3ff6_f105,
			3'b100, 32'h3e5e_3f42, 32'h0);
		exec(packed_alu_pkg::OP_QUAD_BYTE_ADD, packed_alu_pkg::UNIT_L, 32'hff80_7f01, 32'h0180_01ff,
			3'b100, 32'h0000_8000, 32'h0);
		for (int u = 0; u < 3; u++)
			exec(packed_alu_pkg::OP_AND, packed_alu_pkg::unit_t'(u), 32'hf7a1_302a, 32'h02b6_e724,
				3'b100, 32'h02a0_2020, 32'h0);
		uc_v = 1'b1;
		cs_v = 5'h0f;
		exec(packed_alu_pkg::OP_AND, packed_alu_pkg::UNIT_L, 32'h0, 32'h32e4_6936, 3'b100, 32'h0000_0006, 32'h0);
		cs_v = 5'h10;
		exec(packed_alu_pkg::OP_AND, packed_alu_pkg::UNIT_D, 32'h0, 32'h32e4_6936, 3'b100, 32'h32e4_6930, 32'h0);
		uc_v = 1'b0;
	endtask

	// failed predicate, refused units and opfield, then a back-to-back pair
	task automatic t_refuse;
		cd_v = 1'b0;
		exec(packed_alu_pkg::OP_PAIRED_HALFWORD_ADD_SUB, packed_alu_pkg::UNIT_L, 32'h1, 32'h1, 3'b000, 0, 0);
		exec(packed_alu_pkg::OP_QUAD_BYTE_ADD, packed_alu_pkg::UNIT_S, 32'h1, 32'h1, 3'b001, 0, 0);
		cd_v = 1'b1;
		exec(packed_alu_pkg::OP_QUAD_BYTE_ADD, packed_alu_pkg::UNIT_S, 32'h1, 32'h1, 3'b001, 0, 0);
		exec(packed_alu_pkg::OP_PAIRED_HALFWORD_ADD_SUB, packed_alu_pkg::UNIT_S, 32'h1, 32'h1, 3'b001, 0, 0);
		exec(packed_alu_pkg::OP_DUAL_HALFWORD_ADD, packed_alu_pkg::UNIT_M, 32'h1, 32'h1, 3'b001, 0, 0);
		exec(packed_alu_pkg::OP_UNSIGNED_LONG_ADD, packed_alu_pkg::UNIT_D, 32'h1, 32'h1, 3'b001, 0, 0);
		exec(packed_alu_pkg::OP_AND, packed_alu_pkg::UNIT_M, 32'h1, 32'h1, 3'b001, 0, 0);
		opf_v = 7'h2a;
		exec(packed_alu_pkg::OP_UNSIGNED_LONG_ADD, packed_alu_pkg::UNIT_L, 32'h1, 32'h1, 3'b001, 0, 0);
		@(posedge clk_i);
		#1 chk("pair_even", exp_even, even_q);
		chk("pair_odd", exp_odd, odd_q);
		@(posedge clk_i);
		drive(packed_alu_pkg::OP_QUAD_BYTE_ADD, packed_alu_pkg::UNIT_L, 32'hffff_ffff, 32'h0101_0101);
		@(posedge clk_i);
		drive(packed_alu_pkg::OP_AND, packed_alu_pkg::UNIT_D, 32'hf7a1_302a, 32'h02b6_e724);
		#1 judge(3'b100, 32'h0000_0000, 0);
		@(posedge clk_i);
		valid_i <= 1'b0;
		#1 judge(3'b100, 32'h02a0_2020, 0);
	endtask

	// watchdog against a hang
	initial
	begin
		repeat (1000) @(posedge clk_i);
		n_errors++;
		wrap_up();
	end

	initial
	begin
		{rst_n_i, valid_i, use_cst_i, uc_v, cd_v, cond_true_i} = 6'h01;
		cd_v = 1'b1;
		op_i = packed_alu_pkg::OP_AND;
		unit_i = packed_alu_pkg::UNIT_L;
		{opfield_i, opf_v, cst_i, cs_v, src2_ext_i, ex_v} = '0;
		{src1_i, src2_i, exp_even, exp_odd} = '0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		#1 judge(3'b000, 0, 0);
		t_paired();
		t_long();
		t_lanes();
		t_refuse();
		wrap_up();
	end
endmodule
`default_nettype wire

// [verification/reg_pair_model.sv]
// destination register pair fed by the execute unit's write strobes
`timescale 1ns/1ns
`default_nettype none
module reg_pair_model (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        wr_even_i,
	input  wire logic        wr_odd_i,
	input  wire logic [31:0] even_data_i,
	input  wire logic [31:0] odd_data_i,
	output logic      [31:0] even_q_o,
	output logic      [31:0] odd_q_o
);
	// each register of the pair changes only on its own strobe
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			even_q_o <= 32'h0000_0000;
			odd_q_o  <= 32'h0000_0000;
		end
		else
		begin
			if (wr_even_i)
				even_q_o <= even_data_i;
			if (wr_odd_i)
				odd_q_o <= odd_data_i;
		end
	end
endmodule
`default_nettype wire

// [verilog/lane_adder.sv]
// lane-split adder or subtractor with no carry crossing between lanes
`timescale 1ns/1ns
`default_nettype none
module lane_adder #(
	parameter int unsigned LANE_W = 16,
	parameter int unsigned LANES  = 2,
	parameter bit          SUB    = 1'b0
) (
	input  wire logic [LANE_W*LANES-1:0] a_i,
	input  wire logic [LANE_W*LANES-1:0] b_i,
	output logic      [LANE_W*LANES-1:0] y_o
);
	// each lane computed on its own, carry out dropped
	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : gen_lane
			if (SUB)
			begin : gen_sub
				assign y_o[g*LANE_W +: LANE_W] = a_i[g*LANE_W +: LANE_W] - b_i[g*LANE_W +: LANE_W];
			end
			else
			begin : gen_add
				assign y_o[g*LANE_W +: LANE_W] = a_i[g*LANE_W +: LANE_W] + b_i[g*LANE_W +: LANE_W];
			end
		end
	endgenerate
endmodule
`default_nettype wire

// [verilog/packed_add_logic_execute.sv]
// execute-stage packed add, unsigned long add and bitwise and unit
// Overview of operation
// - the paired add/sub adds each signed half of source two to source one and writes the sums to the odd register.
// - the paired add/sub subtracts each signed half of source two from source one and writes them to the even register.
// - every instruction here takes one cycle with no delay slots, results appear after the first execute edge.
// - the unsigned long add sums its sources, opfield 2b taking two words and 29 taking a word plus a long.
// - the unsigned long add gives a 40-bit unsigned result that wraps with no saturation.
// - the dual halfword add sums each signed half of the sources into the same half of the destination.
// - the low-half carry of the dual halfword add never reaches the high half.
// - the quad byte add runs only on the L unit and adds four bytes without saturation.
// - no byte lane carry of the quad byte add touches another lane.
// - byte lane n of both sources sums into byte lane n of the destination for lanes zero to three.
// - the and instruction writes the bitwise and of its sources and runs on the L, S or D unit.
// - the signed five bit constant of the and instruction is sign-extended to 32 bits first.
`timescale 1ns/1ns
`default_nettype none
module packed_add_logic_execute (
	input  wire logic                                 clk_i,
	input  wire logic                                 rst_n_i,
	input  wire logic                                 valid_i,
	input  wire logic                                 cond_true_i,
	input  wire packed_alu_pkg::op_t                  op_i,
	input  wire packed_alu_pkg::unit_t                unit_i,
	input  wire logic [packed_alu_pkg::OPF_W-1:0]     opfield_i,
	input  wire logic                                 use_cst_i,
	input  wire logic [packed_alu_pkg::CST_W-1:0]     cst_i,
	input  wire logic [packed_alu_pkg::WORD_W-1:0]    src1_i,
	input  wire logic [packed_alu_pkg::WORD_W-1:0]    src2_i,
	input  wire logic [packed_alu_pkg::EXT_W-1:0]     src2_ext_i,
	output logic                                      wr_even_o,
	output logic                                      wr_odd_o,
	output logic [packed_alu_pkg::WORD_W-1:0]         even_data_o,
	output logic [packed_alu_pkg::WORD_W-1:0]         odd_data_o,
	output logic                                      illegal_o
);
	localparam int unsigned W = packed_alu_pkg::WORD_W;

	logic [W-1:0] half_sum;
	logic [W-1:0] half_diff;
	logic [W-1:0] byte_sum;
	logic [W-1:0] and_opnd;
	logic [packed_alu_pkg::LONG_W-1:0] long_b;
	logic [packed_alu_pkg::LONG_W-1:0] long_sum;
	logic legal;
	logic issue;
	logic wr_even_d, wr_even_q;
	logic wr_odd_d, wr_odd_q;
	logic illegal_d, illegal_q;
	logic [W-1:0] even_d, even_q;
	logic [W-1:0] odd_d, odd_q;

	// halfword lanes shared by dual add and paired add/sub
	lane_adder #(.LANE_W(packed_alu_pkg::HALF_W), .LANES(2), .SUB(1'b0)) u_half_add (
		.a_i (src1_i),
		.b_i (src2_i),
		.y_o (half_sum)
	);
	lane_adder #(.LANE_W(packed_alu_pkg::HALF_W), .LANES(2), .SUB(1'b1)) u_half_sub (
		.a_i (src1_i),
		.b_i (src2_i),
		.y_o (half_diff)
	);
	// four independent byte lanes
	lane_adder #(.LANE_W(packed_alu_pkg::BYTE_W), .LANES(4), .SUB(1'b0)) u_byte_add (
		.a_i (src1_i),
		.b_i (src2_i),
		.y_o (byte_sum)
	);

	// operand shaping for and and long add
	always_comb
	begin
		and_opnd = use_cst_i ? {{(W-packed_alu_pkg::CST_W){cst_i[packed_alu_pkg::CST_W-1]}}, cst_i}
		                     : src1_i;
		long_b   = (opfield_i == packed_alu_pkg::OPF_ULONG_EXT) ? {src2_ext_i, src2_i}
		                                                        : {packed_alu_pkg::EXT_ZERO, src2_i};
		long_sum = {packed_alu_pkg::EXT_ZERO, src1_i} + long_b;
	end

	// unit and form legality
	always_comb
	begin
		unique case (op_i)
			packed_alu_pkg::OP_AND:
				legal = (unit_i != packed_alu_pkg::UNIT_M);
			packed_alu_pkg::OP_DUAL_HALFWORD_ADD:
				legal = (unit_i != packed_alu_pkg::UNIT_M);
			packed_alu_pkg::OP_QUAD_BYTE_ADD:
				legal = (unit_i == packed_alu_pkg::UNIT_L);
			packed_alu_pkg::OP_PAIRED_HALFWORD_ADD_SUB:
				legal = (unit_i == packed_alu_pkg::UNIT_L);
			packed_alu_pkg::OP_UNSIGNED_LONG_ADD:
				legal = (unit_i == packed_alu_pkg::UNIT_L)
				        && (opfield_i == packed_alu_pkg::OPF_ULONG_WORD
				            || opfield_i == packed_alu_pkg::OPF_ULONG_EXT);
			default:
				legal = 1'b0;
		endcase
		issue = valid_i && cond_true_i && legal;
	end

	// next result stage values
	always_comb
	begin
		wr_even_d = 1'b0;
		wr_odd_d  = 1'b0;
		illegal_d = valid_i && !legal;
		even_d    = even_q;
		odd_d     = odd_q;
		if (issue)
		begin
			unique case (op_i)
				packed_alu_pkg::OP_AND:
				begin
					wr_even_d = 1'b1;
					even_d    = and_opnd & src2_i;
				end
				packed_alu_pkg::OP_DUAL_HALFWORD_ADD:
				begin
					wr_even_d = 1'b1;
					even_d    = half_sum;
				end
				packed_alu_pkg::OP_QUAD_BYTE_ADD:
				begin
					wr_even_d = 1'b1;
					even_d    = byte_sum;
				end
				packed_alu_pkg::OP_PAIRED_HALFWORD_ADD_SUB:
				begin
					wr_even_d = 1'b1;
					wr_odd_d  = 1'b1;
					odd_d     = half_sum;
					even_d    = half_diff;
				end
				packed_alu_pkg::OP_UNSIGNED_LONG_ADD:
				begin
					wr_even_d = 1'b1;
					wr_odd_d  = 1'b1;
					even_d    = long_sum[W-1:0];
					odd_d     = {packed_alu_pkg::HI_PAD, long_sum[packed_alu_pkg::LONG_W-1:W]};
				end
				default:
				begin
					wr_even_d = 1'b0;
				end
			endcase
		end
	end

	// result stage registers
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			wr_even_q <= 1'b0;
			wr_odd_q  <= 1'b0;
			illegal_q <= 1'b0;
			even_q    <= packed_alu_pkg::RESULT_RST;
			odd_q     <= packed_alu_pkg::RESULT_RST;
		end
		else
		begin
			wr_even_q <= wr_even_d;
			wr_odd_q  <= wr_odd_d;
			illegal_q <= illegal_d;
			even_q    <= even_d;
			odd_q     <= odd_d;
		end
	end

	// outputs straight from the result stage
	assign wr_even_o   = wr_even_q;
	assign wr_odd_o    = wr_odd_q;
	assign illegal_o   = illegal_q;
	assign even_data_o = even_q;
	assign odd_data_o  = odd_q;

	// checks on the result stage
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_paired_sum: assert property (wr_odd_o && $past(op_i) == packed_alu_pkg::OP_PAIRED_HALFWORD_ADD_SUB
		|-> odd_data_o[31:16] == 16'($past(src1_i[31:16]) + $past(src2_i[31:16]))
		 && odd_data_o[15:0] == 16'($past(src1_i[15:0]) + $past(src2_i[15:0])))
		else $error("paired add/sub sum wrong");
	a_paired_diff: assert property (wr_even_o && $past(op_i) == packed_alu_pkg::OP_PAIRED_HALFWORD_ADD_SUB
		|-> even_data_o[31:16] == 16'($past(src1_i[31:16]) - $past(src2_i[31:16]))
		 && even_data_o[15:0] == 16'($past(src1_i[15:0]) - $past(src2_i[15:0])))
		else $error("paired add/sub difference wrong");
	a_single_cycle: assert property (issue |=> wr_even_o ##1 (!wr_even_o || $past(issue)))
		else $error("result not written one cycle after issue");
	a_long_wrap: assert property (wr_odd_o && $past(op_i) == packed_alu_pkg::OP_UNSIGNED_LONG_ADD
		|-> {odd_data_o[7:0], even_data_o} == 40'({8'h00, $past(src1_i)}
		    + ($past(opfield_i) == packed_alu_pkg::OPF_ULONG_EXT ? {$past(src2_ext_i), $past(src2_i)}
		                                                         : {8'h00, $past(src2_i)})))
		else $error("unsigned long add result wrong");
	a_long_split: assert property (wr_odd_o && $past(op_i) == packed_alu_pkg::OP_UNSIGNED_LONG_ADD
		|-> odd_data_o[31:8] == 24'h00_0000)
		else $error("long result upper bits not clear");
	a_dual_halves: assert property (wr_even_o && $past(op_i) == packed_alu_pkg::OP_DUAL_HALFWORD_ADD
		|-> even_data_o[31:16] == 16'($past(src1_i[31:16]) + $past(src2_i[31:16]))
		 && even_data_o[15:0] == 16'($past(src1_i[15:0]) + $past(src2_i[15:0])))
		else $error("dual halfword add carried across halves");
	a_quad_lanes: assert property (wr_even_o && $past(op_i) == packed_alu_pkg::OP_QUAD_BYTE_ADD
		|-> even_data_o[31:24] == 8'($past(src1_i[31:24]) + $past(src2_i[31:24]))
		 && even_data_o[23:16] == 8'($past(src1_i[23:16]) + $past(src2_i[23:16]))
		 && even_data_o[15:8] == 8'($past(src1_i[15:8]) + $past(src2_i[15:8]))
		 && even_data_o[7:0] == 8'($past(src1_i[7:0]) + $past(src2_i[7:0])))
		else $error("quad byte add lane wrong");
	a_quad_unit: assert property (valid_i && op_i == packed_alu_pkg::OP_QUAD_BYTE_ADD
		&& unit_i != packed_alu_pkg::UNIT_L |=> illegal_o && !wr_even_o)
		else $error("quad byte add accepted off the L unit");
	a_and_const: assert property (wr_even_o && $past(op_i) == packed_alu_pkg::OP_AND && $past(use_cst_i)
		|-> even_data_o == ({{27{$past(cst_i[4])}}, $past(cst_i)} & $past(src2_i)))
		else $error("and with constant wrong");
	a_and_reg: assert property (wr_even_o && $past(op_i) == packed_alu_pkg::OP_AND && !$past(use_cst_i)
		|-> even_data_o == ($past(src1_i) & $past(src2_i)))
		else $error("and with register wrong");
	a_pred_nop: assert property (valid_i && !cond_true_i |=> !wr_even_o && !wr_odd_o
		&& $stable(even_data_o) && $stable(odd_data_o))
		else $error("false predicate changed a result");

	c_paired: cover property (issue && op_i == packed_alu_pkg::OP_PAIRED_HALFWORD_ADD_SUB ##1 wr_odd_o);
	c_long: cover property (issue && op_i == packed_alu_pkg::OP_UNSIGNED_LONG_ADD
		&& opfield_i == packed_alu_pkg::OPF_ULONG_EXT ##1 odd_data_o[7:0] != 8'h00);
	c_quad: cover property (issue && op_i == packed_alu_pkg::OP_QUAD_BYTE_ADD ##1 issue);
	c_pred: cover property (valid_i && !cond_true_i);
endmodule
`default_nettype wire

// [verilog/packed_alu_pkg.sv]
// constants and types shared by the packed add and logic execute unit
package packed_alu_pkg;
	localparam int unsigned WORD_W = 32;
	localparam int unsigned HALF_W = 16;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned LONG_W = 40;
	localparam int unsigned EXT_W  = LONG_W - WORD_W;
	localparam int unsigned CST_W  = 5;
	localparam int unsigned OPF_W  = 7;

	// opfield values selecting the unsigned long add form
	localparam logic [OPF_W-1:0] OPF_ULONG_WORD = 7'h2b;
	localparam logic [OPF_W-1:0] OPF_ULONG_EXT  = 7'h29;

	// reset value of the result stage and zero fill for the long add operands and odd word
	localparam logic [WORD_W-1:0] RESULT_RST = 32'h0000_0000;
	localparam logic [EXT_W-1:0]  EXT_ZERO   = 8'h00;
	localparam logic [WORD_W-EXT_W-1:0] HI_PAD = 24'h00_0000;

	// instruction selected by decode
	typedef enum logic [2:0] {
		OP_AND,
		OP_DUAL_HALFWORD_ADD,
		OP_QUAD_BYTE_ADD,
		OP_PAIRED_HALFWORD_ADD_SUB,
		OP_UNSIGNED_LONG_ADD
	} op_t;

	// functional unit issuing the instruction
	typedef enum logic [1:0] {
		UNIT_L,
		UNIT_S,
		UNIT_D,
		UNIT_M
	} unit_t;
endpackage
